// file: core/flash_erase_host.sv
// How it works
// RL1 - Device reports buffer free in top extended bit.
// RL2 - Host masks the seven reserved extended bits.
// RL3 - Error flags stay set until clear status.
// RL4 - Code 50H clears flags regardless of supply.
// RL5 - Clear status only when idle or suspended.
// RL6 - Erase is setup plus confirm, same block.
// RL7 - Finished erase leaves block all ones.
// RL8 - After erase confirm, reads return status.
// RL9 - Erase done seen on pin and ready flag.
// RL10 - Status refreshes only when an enable toggles.
// RL11 - Host checks erase error, clears before retrying.
// RL12 - Bad confirm sets program and erase errors.
// RL13 - Low supply sets supply and erase errors.
// RL14 - Locked block aborts erase, sets lock error.
// RL15 - Suspend pauses erase; reads return status.
// RL16 - Suspended: ready and suspended flags set, pin high.
// RL17 - Suspended: read or program other blocks only.
// RL18 - Programming in suspend: ready low, suspended stays.
// RL19 - Program in suspend may itself suspend, resume.
// RL20 - Suspended: only listed commands are accepted.
// RL21 - Resume continues erase, clears ready and suspended.
// RL22 - Resume only after suspend-time program finished.
// RL23 - Lock flag reads one only after lock abort.
// RL24 - Erase opcodes come from the command table.
//
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`default_nettype none

module flash_erase_host
	import flash_host_pkg::*;
(
	// Clock and reset.
	input  wire logic              ref_clk,
	input  wire logic              arst_n,
	// Software register port.
	input  wire logic [7:0]        reg_addr,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic [31:0]            reg_rdata,
	// Flash pins.
	output logic [ADDR_W-1:0]      flash_addr,
	output logic [7:0]             dq_out,
	output logic                   dq_oe_n,
	input  wire logic [7:0]        dq_in,
	output logic                   ce_n,
	output logic                   oe_n,
	output logic                   we_n,
	input  wire logic              ready_status_pin
);

	typedef struct packed {
		seq_t              seq;
		op_t               op;
		tail_t             tail;
		logic              two_wr;
		logic [7:0]        c2;
		logic              req;
		logic              wr;
		logic [7:0]        wdata;
		logic [ADDR_W-1:0] addr;
		logic [7:0]        data;
		logic              refused;
		logic              erasing;
		logic              susp;
		logic [BLK_W-1:0]  erase_blk;
		logic              eerr;
		logic              buf_free;
		logic              pin;
		logic [7:0]        sr;
		logic [31:0]       rdata;
	} host_t;

	function automatic logic [BLK_W-1:0] blk_of(input logic [ADDR_W-1:0] a);
		return a[ADDR_W-1:BLOCK_LSB];
	endfunction

	host_t       s;
	host_t       n;
	pin_cycle_if cyc ();
	op_t         ctl_op;
	logic        ctl_wr;
	logic        other_blk;
	logic        ok;

	flash_pin_cycle u_cycle (
		.ref_clk    (ref_clk),
		.arst_n     (arst_n),
		.cyc        (cyc.eng),
		.flash_addr (flash_addr),
		.dq_out     (dq_out),
		.dq_oe_n    (dq_oe_n),
		.dq_in      (dq_in),
		.ce_n       (ce_n),
		.oe_n       (oe_n),
		.we_n       (we_n)
	);

	assign cyc.req = s.req;
	assign cyc.wr = s.wr;
	assign cyc.addr = s.addr;
	assign cyc.wdata = s.wdata;
	assign ctl_op = op_t'(reg_wdata[2:0]);
	assign ctl_wr = reg_wr && (reg_addr == REG_CTRL);
	assign other_blk = blk_of(s.addr) != s.erase_blk;

	// ----------------------------------------------------------------
	// Which orders the flash may take in the present state
	// ----------------------------------------------------------------
	always_comb begin
		unique case (ctl_op)
			OP_ERASE:   ok = !s.erasing && !s.eerr; // [RL11]
			OP_SUSPEND: ok = s.erasing && !s.susp;
			OP_RESUME:  ok = s.susp; // [RL22]
			OP_CLEAR:   ok = !s.erasing || s.susp; // [RL5]
			OP_PROGRAM: ok = !s.eerr && (!s.erasing || (s.susp && other_blk));
			OP_POLL:    ok = 1'b1;
			default:    ok = !s.erasing || (s.susp && other_blk); // [RL17]
		endcase
	end

	// ----------------------------------------------------------------
	// Sequencer and registers
	// ----------------------------------------------------------------
	always_comb begin
		n = s;
		n.req = 1'b0;
		n.rdata = 32'h0;
		n.pin = ready_status_pin;
		if (reg_wr && reg_addr == REG_ADDR && s.seq == S_IDLE) begin
			n.addr = reg_wdata[ADDR_W-1:0];
		end
		if (reg_wr && reg_addr == REG_DATA) begin
			n.data = reg_wdata[7:0];
		end
		if (reg_rd) begin
			unique case (reg_addr)
				REG_ADDR:   n.rdata = 32'(s.addr);
				REG_DATA:   n.rdata = 32'(s.data);
				REG_STATUS: begin
					n.rdata[ST_SR_LSB +: 8] = s.sr;
					n.rdata[ST_BUSY] = s.seq != S_IDLE;
					n.rdata[ST_REFUSED] = s.refused;
					n.rdata[ST_SUSP] = s.susp;
					n.rdata[ST_ERASING] = s.erasing;
					n.rdata[ST_EERR] = s.eerr;
					n.rdata[ST_BUF] = s.buf_free;
					n.rdata[ST_PIN] = s.pin;
				end
				default:    n.rdata = 32'h0;
			endcase
		end
		unique case (s.seq)
			S_IDLE: if (ctl_wr) begin
				// Anything outside the suspend command set is refused. [RL20]
				n.refused = !ok;
				if (ok) begin
					n.op = ctl_op;
					n.seq = S_CMD1;
					n.req = 1'b1;
					n.wr = 1'b1;
					n.two_wr = 1'b0;
					n.tail = T_NONE;
					unique case (ctl_op)
						OP_ERASE: begin
							// Setup and confirm both carry the block address. [RL6] [RL24]
							n.wdata = CMD_ERASE_SETUP;
							n.c2 = CMD_ERASE_CONFIRM;
							n.two_wr = 1'b1;
							n.erase_blk = blk_of(s.addr);
							n.erasing = 1'b1;
						end
						OP_SUSPEND: begin
							n.wdata = CMD_ERASE_SUSPEND;
							n.tail = T_POLL;
						end
						OP_RESUME: begin
							n.wdata = CMD_ERASE_RESUME;
							n.susp = 1'b0;
						end
						OP_CLEAR: begin
							n.wdata = CMD_CLEAR_STATUS; // [RL4]
							n.eerr = 1'b0;
						end
						OP_PROGRAM: begin
							n.wdata = CMD_PROGRAM_SETUP;
							n.c2 = s.data;
							n.two_wr = 1'b1;
							n.tail = T_POLL;
						end
						OP_READ: begin
							n.wdata = CMD_READ_ARRAY;
							n.tail = T_READ;
						end
						OP_BUF_QUERY: begin
							n.wdata = CMD_BUFFER_SETUP;
							n.tail = T_READ;
						end
						default: begin
							n.wdata = CMD_READ_STATUS;
							n.tail = T_POLL;
						end
					endcase
				end
			end
			S_CMD1: if (cyc.done) begin
				n.seq = s.two_wr ? S_CMD2 : S_TAIL;
				n.req = s.two_wr;
				n.wdata = s.c2;
			end
			S_CMD2: if (cyc.done) begin
				n.seq = S_TAIL;
			end
			S_TAIL: begin
				n.seq = (s.tail == T_POLL) ? S_POLL :
					(s.tail == T_READ) ? S_READ : S_IDLE;
				n.req = s.tail != T_NONE;
				n.wr = 1'b0;
			end
			S_POLL: if (cyc.done) begin
				n.sr = cyc.rdata;
				// Keep reading until the ready flag shows. [RL9]
				if (!cyc.rdata[SR_READY]) begin
					n.req = 1'b1;
				end else begin
					n.seq = S_IDLE;
					if (s.erasing && !s.susp) begin
						n.susp = cyc.rdata[SR_ESUSP];
						n.erasing = cyc.rdata[SR_ESUSP];
						n.eerr = cyc.rdata[SR_EERR]; // [RL11]
					end
				end
			end
			S_READ: if (cyc.done) begin
				n.seq = S_IDLE;
				if (s.op == OP_BUF_QUERY) begin
					n.buf_free = cyc.rdata[BUF_FREE_BIT]; // [RL2]
				end else begin
					n.data = cyc.rdata;
				end
			end
			default: n.seq = S_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			s <= '{seq: S_IDLE, op: OP_POLL, tail: T_NONE, default: '0};
		end else begin
			s <= n;
		end
	end

	assign reg_rdata = s.rdata;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	clear_when_idle_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // [RL5]
		s.req && s.wr && s.seq == S_CMD1 && s.op == OP_CLEAR
		|-> s.wdata == CMD_CLEAR_STATUS && (!s.erasing || s.susp))
		else $error("clear status sent while the erase runs");
	erase_confirm_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // [RL6]
		s.req && s.seq == S_CMD2 && s.op == OP_ERASE
		|-> s.wdata == CMD_ERASE_CONFIRM && blk_of(s.addr) == s.erase_blk)
		else $error("erase confirm wrong or in another block");
	buf_mask_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // [RL2]
		s.seq == S_READ && cyc.done && s.op == OP_BUF_QUERY
		|=> s.buf_free == $past(cyc.rdata[BUF_FREE_BIT]) && s.seq == S_IDLE)
		else $error("buffer free bit not taken from the top bit");
	erase_after_err_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // [RL11]
		s.eerr && s.seq == S_IDLE && ctl_wr && ctl_op == OP_ERASE
		|=> s.refused && s.seq == S_IDLE)
		else $error("erase taken before the error was cleared");
	suspend_set_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // [RL20]
		s.susp && s.seq == S_IDLE && ctl_wr && ctl_op == OP_ERASE
		|=> s.refused && s.seq == S_IDLE)
		else $error("erase taken while suspended");
	resume_order_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // [RL22]
		s.req && s.wr && s.seq == S_CMD1 && s.op == OP_RESUME
		|-> $past(s.seq, 2) == S_IDLE && $past(s.susp) && !s.susp && s.erasing)
		else $error("resume sent with a program still running");
	status_read_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		reg_rd && reg_addr == REG_STATUS
		|=> reg_rdata[ST_SR_LSB +: 8] == $past(s.sr) ##1 reg_rdata == 32'h0
		|| $past(reg_rd))
		else $error("status word not shown for one cycle");
	poll_ends_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // [RL9]
		s.seq == S_POLL && cyc.done && cyc.rdata[SR_READY] |=> s.seq == S_IDLE)
		else $error("poll ran past a ready status");

endmodule

`default_nettype wire

// file: core/flash_host_pkg.sv
package flash_host_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_NS       = 50;
	localparam int T_STROBE_NS  = 70;
	localparam int T_ACCESS_NS  = 150;
	localparam int T_RECOVER_NS = 50;

	// A least time rounds up and never falls below one cycle.
	function automatic logic [3:0] cyc_of(input int ns);
		int c;
		c = (ns + CLK_NS - 1) / CLK_NS;
		return (c < 1) ? 4'h1 : 4'(c);
	endfunction

	localparam logic [3:0] STROBE_CYC  = cyc_of(T_STROBE_NS);
	localparam logic [3:0] ACCESS_CYC  = cyc_of(T_ACCESS_NS);
	localparam logic [3:0] RECOVER_CYC = cyc_of(T_RECOVER_NS);

	// ----------------------------------------------------------------
	// Flash geometry and device commands
	// ----------------------------------------------------------------
	localparam int ADDR_W    = 24;
	localparam int BLOCK_LSB = 16;
	localparam int BLK_W     = ADDR_W - BLOCK_LSB;
	localparam logic [7:0] CMD_CLEAR_STATUS  = 8'h50;
	// Set these from the part's command table.
	localparam logic [7:0] CMD_ERASE_SETUP   = 8'h20;
	localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hd0;
	localparam logic [7:0] CMD_ERASE_SUSPEND = 8'hb0;
	localparam logic [7:0] CMD_ERASE_RESUME  = 8'hd0;
	localparam logic [7:0] CMD_PROGRAM_SETUP = 8'h40;
	localparam logic [7:0] CMD_READ_ARRAY    = 8'hff;
	localparam logic [7:0] CMD_READ_STATUS   = 8'h70;
	localparam logic [7:0] CMD_BUFFER_SETUP  = 8'he8;

	// ----------------------------------------------------------------
	// Status byte bits
	// ----------------------------------------------------------------
	localparam int SR_READY  = 7;
	localparam int SR_ESUSP  = 6;
	localparam int SR_EERR   = 5;
	localparam int BUF_FREE_BIT = 7;

	// ----------------------------------------------------------------
	// Software register map
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_ADDR   = 8'h04;
	localparam logic [7:0] REG_DATA   = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;
	localparam int ST_BUSY    = 0;
	localparam int ST_REFUSED = 1;
	localparam int ST_SUSP    = 2;
	localparam int ST_ERASING = 3;
	localparam int ST_EERR    = 4;
	localparam int ST_BUF     = 5;
	localparam int ST_PIN     = 6;
	localparam int ST_SR_LSB  = 8;

	typedef enum logic [2:0] {
		OP_POLL    = 3'h0,
		OP_ERASE   = 3'h1,
		OP_SUSPEND = 3'h2,
		OP_RESUME  = 3'h3,
		OP_CLEAR   = 3'h4,
		OP_PROGRAM = 3'h5,
		OP_READ    = 3'h6,
		OP_BUF_QUERY = 3'h7
	} op_t;

	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_ACT  = 2'b01,
		PH_REC  = 2'b11
	} phase_t;

	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_CMD1 = 3'b001,
		S_CMD2 = 3'b011,
		S_TAIL = 3'b010,
		S_POLL = 3'b110,
		S_READ = 3'b111
	} seq_t;

	typedef enum logic [1:0] {
		T_NONE = 2'h0,
		T_POLL = 2'h1,
		T_READ = 2'h2
	} tail_t;

endpackage

// file: core/pin_cycle_if.sv
`timescale 1ns/10ps
`default_nettype none

interface pin_cycle_if;
	import flash_host_pkg::*;
	logic              req;
	logic              wr;
	logic [ADDR_W-1:0] addr;
	logic [7:0]        wdata;
	logic              done;
	logic [7:0]        rdata;
	modport ctl (output req, output wr, output addr, output wdata,
		input done, input rdata);
	modport eng (input req, input wr, input addr, input wdata,
		output done, output rdata);
endinterface

`default_nettype wire

// file: core/flash_pin_cycle.sv
`timescale 1ns/10ps
`default_nettype none

module flash_pin_cycle
	import flash_host_pkg::*;
(
	// Clock and reset.
	input  wire logic              ref_clk,
	input  wire logic              arst_n,
	// Cycle requests.
	pin_cycle_if.eng               cyc,
	// Flash pins.
	output logic [ADDR_W-1:0]      flash_addr,
	output logic [7:0]             dq_out,
	output logic                   dq_oe_n,
	input  wire logic [7:0]        dq_in,
	output logic                   ce_n,
	output logic                   oe_n,
	output logic                   we_n
);

	typedef struct packed {
		phase_t            phase;
		logic [3:0]        cnt;
		logic              wr;
		logic [ADDR_W-1:0] addr;
		logic [7:0]        wdata;
		logic              dq_oe_n;
		logic              ce_n;
		logic              oe_n;
		logic              we_n;
		logic              done;
		logic [7:0]        rdata;
	} eng_t;

	eng_t s;
	eng_t n;

	// ----------------------------------------------------------------
	// One bus cycle: strobe, then recovery with all strobes high
	// ----------------------------------------------------------------
	always_comb begin
		n = s;
		n.done = 1'b0;
		unique case (s.phase)
			PH_IDLE: if (cyc.req) begin
				n.phase = PH_ACT;
				n.wr = cyc.wr;
				n.addr = cyc.addr;
				n.wdata = cyc.wdata;
				n.ce_n = 1'b0;
				n.we_n = !cyc.wr;
				n.oe_n = cyc.wr;
				n.dq_oe_n = !cyc.wr;
				n.cnt = cyc.wr ? STROBE_CYC : ACCESS_CYC;
			end
			PH_ACT: if (s.cnt == 4'h1) begin
				// Each read ends with enables high, so the next read refreshes status. [RL10]
				n.phase = PH_REC;
				n.ce_n = 1'b1;
				n.oe_n = 1'b1;
				n.we_n = 1'b1;
				n.cnt = RECOVER_CYC;
				if (!s.wr) begin
					n.rdata = dq_in;
				end
			end else begin
				n.cnt = s.cnt - 4'h1;
			end
			PH_REC: if (s.cnt == 4'h1) begin
				n.phase = PH_IDLE;
				n.dq_oe_n = 1'b1;
				n.done = 1'b1;
			end else begin
				n.cnt = s.cnt - 4'h1;
			end
			default: n.phase = PH_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			s <= '{phase: PH_IDLE, dq_oe_n: 1'b1, ce_n: 1'b1, oe_n: 1'b1,
				we_n: 1'b1, default: '0};
		end else begin
			s <= n;
		end
	end

	assign flash_addr = s.addr;
	assign dq_out = s.wdata;
	assign dq_oe_n = s.dq_oe_n;
	assign ce_n = s.ce_n;
	assign oe_n = s.oe_n;
	assign we_n = s.we_n;
	assign cyc.done = s.done;
	assign cyc.rdata = s.rdata;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	oe_toggle_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // [RL10]
		$fell(oe_n) |-> !oe_n [*3] ##1 oe_n)
		else $error("output enable not released after a read");
	we_width_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		$fell(we_n) |-> !we_n ##1 !we_n ##1 we_n)
		else $error("write strobe width wrong");
	data_drive_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		!we_n |-> !dq_oe_n && oe_n)
		else $error("data not driven during write strobe");

endmodule

`default_nettype wire

// file: bench/flash_device_model.sv
`timescale 1ns/10ps
`default_nettype none

module flash_device_model
	import flash_host_pkg::*;
#(
	parameter int ERASE_TICKS = 300,
	parameter int PROG_TICKS  = 12,
	parameter int SUSP_TICKS  = 5
)(
	// Bus pins.
	input  wire logic [ADDR_W-1:0] flash_addr,
	input  wire logic [7:0]        dq_out,
	input  wire logic              dq_oe_n,
	input  wire logic              ce_n,
	input  wire logic              oe_n,
	input  wire logic              we_n,
	output logic [7:0]             dq_in,
	output logic                   ready_status_pin,
	// Board conditions.
	input  wire logic              supply_ok,
	input  wire logic [BLK_W-1:0]  locked_blk,
	input  wire logic              lock_on
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [7:0]       mem [int];
	int               wipe_q [$];
	logic [5:1]       err = '0;
	logic             rdy = 1'b1;
	logic             susp = 1'b0;
	logic             psusp = 1'b0;
	logic [1:0]       mode = 2'h0;
	logic [1:0]       pend = 2'h0;
	logic [BLK_W-1:0] pblk = '0;
	logic [BLK_W-1:0] eblk = '0;
	int               e_left = 0;
	int               p_left = 0;
	int               s_left = 0;
	logic [7:0]       out_r = 8'h00;
	logic [6:0]       junk = 7'h2a;

	assign ready_status_pin = rdy;
	// A released bus shows the inverse of the last byte, never a stale copy.
	assign dq_in = (!ce_n && !oe_n) ? out_r : ~out_r;

	function automatic logic [7:0] rd_mem(input int a);
		return mem.exists(a) ? mem[a] : 8'hff;
	endfunction

	// ----------------------------------------------------------------
	// Read output, refreshed only by a falling enable
	// ----------------------------------------------------------------
	always @(negedge oe_n or negedge ce_n) begin
		#1;
		junk = junk + 7'h13;
		case (mode)
			2'h1: out_r = {rdy, susp, err, 1'b0};
			2'h2: out_r = {rdy, junk};
			default: out_r = rd_mem(int'(flash_addr));
		endcase
	end

	// ----------------------------------------------------------------
	// Command front end
	// ----------------------------------------------------------------
	task automatic command(input logic [7:0] c, input logic [ADDR_W-1:0] a);
		logic [BLK_W-1:0] b;
		b = a[ADDR_W-1:BLOCK_LSB];
		mode = 2'h1;
		if (pend == 2'h1) begin
			pend = 2'h0;
			if (c != CMD_ERASE_CONFIRM || b != pblk) begin
				err[5:4] = 2'b11;
			end else if (!supply_ok) begin
				{err[5], err[3]} = 2'b11;
			end else if (lock_on && locked_blk == b) begin
				{err[5], err[1]} = 2'b11;
			end else begin
				eblk = b;
				e_left = ERASE_TICKS;
				rdy = 1'b0;
			end
		end else if (pend == 2'h2) begin
			pend = 2'h0;
			if (!supply_ok) begin
				{err[4], err[3]} = 2'b11;
			end else if (lock_on && locked_blk == b) begin
				{err[4], err[1]} = 2'b11;
			end else begin
				mem[int'(a)] = rd_mem(int'(a)) & c;
				p_left = PROG_TICKS;
				rdy = 1'b0;
			end
		end else begin
			case (c)
				CMD_CLEAR_STATUS: if (rdy || susp) err = '0;
				CMD_ERASE_SETUP: begin
					if (susp) err[5:4] = 2'b11;
					else pend = 2'h1;
					pblk = b;
				end
				CMD_ERASE_SUSPEND: begin
					if (p_left > 0) {psusp, rdy} = 2'b11;
					else if (e_left > 0) s_left = SUSP_TICKS;
				end
				CMD_ERASE_RESUME: begin
					if (psusp) {psusp, rdy} = 2'b00;
					else if (susp && p_left == 0) begin
						susp = 1'b0;
						rdy = 1'b0;
					end
				end
				CMD_PROGRAM_SETUP: begin
					if (susp && b == eblk) err[5:4] = 2'b11;
					else pend = 2'h2;
				end
				CMD_READ_ARRAY: mode = 2'h0;
				CMD_BUFFER_SETUP: mode = 2'h2;
				default: mode = 2'h1;
			endcase
		end
	endtask

	always @(posedge we_n) begin
		if (dq_oe_n === 1'b0) command(dq_out, flash_addr);
	end

	// ----------------------------------------------------------------
	// Internal algorithm timing
	// ----------------------------------------------------------------
	always #100 begin
		if (s_left > 0) begin
			s_left--;
			if (s_left == 0) {susp, rdy} = 2'b11;
		end else if (p_left > 0 && !psusp) begin
			p_left--;
			if (p_left == 0) rdy = 1'b1;
		end else if (e_left > 0 && !susp) begin
			e_left--;
			if (e_left == 0) begin
				wipe_q.delete();
				foreach (mem[k]) if ((k >> BLOCK_LSB) == int'(eblk)) wipe_q.push_back(k);
				foreach (wipe_q[i]) mem.delete(wipe_q[i]);
				rdy = 1'b1;
			end
		end
	end
endmodule

`default_nettype wire

// file: bench/flash_erase_host_bench.sv
`timescale 1ns/10ps
`default_nettype none

module flash_erase_host_bench;
	import flash_host_pkg::*;
	logic              ref_clk = 1'b0;
	logic              arst_n, reg_wr, reg_rd, dq_oe_n, ce_n, oe_n, we_n;
	logic [7:0]        reg_addr, dq_out, dq_in, dat;
	logic [31:0]       reg_wdata, reg_rdata, st;
	logic [ADDR_W-1:0] flash_addr, adr_a, adr_b;
	logic              ready_status_pin, supply_ok, lock_on;
	logic [BLK_W-1:0]  locked_blk;
	int                n_mismatch = 0;
	int                comparisons = 0;
	int                seed = 37556;

	always #25 ref_clk = ~ref_clk;

	flash_erase_host i_dut (.ref_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .flash_addr, .dq_out, .dq_oe_n, .dq_in, .ce_n,
		.oe_n, .we_n, .ready_status_pin);
	flash_device_model i_dev (.flash_addr, .dq_out, .dq_oe_n, .ce_n, .oe_n,
		.we_n, .dq_in, .ready_status_pin, .supply_ok, .locked_blk, .lock_on);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] fail_st(input logic low, input logic lock);
		return {16'h0, 8'ha0 | {4'h0, low, 1'b0, lock, 1'b0}, 8'h10};
	endfunction

	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] exp, input logic [31:0] mask);
		comparisons++;
		if ((st & mask) !== exp) begin
			n_mismatch++;
			$display("MISMATCH %0t got %h expected %h", $time, st & mask, exp);
		end
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge ref_clk);
		reg_wr    <= 1'b0;
	endtask

	task automatic reg_read(input logic [7:0] a);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge ref_clk);
		reg_rd   <= 1'b0;
		#1;
		st = reg_rdata;
	endtask

	// The wait is bounded so that a stuck sequencer shows as a mismatch.
	task automatic do_op(input op_t op, input logic [ADDR_W-1:0] a);
		int n;
		n = 0;
		reg_write(REG_ADDR, {8'h00, a});
		reg_write(REG_DATA, {24'h0, dat});
		reg_write(REG_CTRL, {29'h0, op});
		reg_read(REG_STATUS);
		while (st[ST_BUSY] !== 1'b0 && n < 5000) begin
			reg_read(REG_STATUS);
			n++;
		end
		if (n == 5000) check(32'h0, 32'h1);
	endtask

	task automatic read_back(input logic [ADDR_W-1:0] a);
		do_op(OP_READ, a);
		reg_read(REG_DATA);
	endtask

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		{arst_n, reg_wr, reg_rd, lock_on} = 4'b0000;
		{reg_addr, reg_wdata, dat, locked_blk} = '0;
		supply_ok = 1'b1;
		repeat (4) @(posedge ref_clk);
		arst_n <= 1'b1;
		reg_read(REG_STATUS);
		check(32'h40, 32'h5f);
		reg_read(8'h10);
		check(32'h0, 32'hffffffff);
		for (int i = 0; i < 3; i++) begin
			adr_a = 24'($random(seed));
			dat = 8'($random(seed));
			do_op(OP_PROGRAM, adr_a);
			read_back(adr_a);
			check({24'h0, dat}, 32'hff);
			do_op(OP_ERASE, adr_a);
			check(32'h08, 32'h48);
			do_op(OP_POLL, adr_a);
			check(32'h8040, 32'hff58);
			read_back(adr_a);
			check(32'hff, 32'hff);
		end
		adr_b = {adr_a[23:16] + 8'h01, 16'($random(seed))};
		dat = 8'($random(seed));
		do_op(OP_ERASE, adr_a);
		do_op(OP_CLEAR, adr_a);
		check(32'h2, 32'h2);
		do_op(OP_SUSPEND, adr_a);
		check(32'hc044, 32'hc046);
		do_op(OP_ERASE, adr_b);
		check(32'h2, 32'h2);
		do_op(OP_PROGRAM, adr_a);
		check(32'h2, 32'h2);
		do_op(OP_PROGRAM, adr_b);
		check(32'hc004, 32'hc006);
		read_back(adr_b);
		check({24'h0, dat}, 32'hff);
		do_op(OP_CLEAR, adr_a);
		check(32'h0, 32'h2);
		do_op(OP_RESUME, adr_a);
		check(32'h08, 32'h4c);
		do_op(OP_POLL, adr_a);
		check(32'h8040, 32'hff58);
		locked_blk <= adr_a[23:16];
		lock_on <= 1'b1;
		do_op(OP_ERASE, adr_a);
		do_op(OP_POLL, adr_a);
		check(fail_st(1'b0, 1'b1), 32'hff10);
		do_op(OP_ERASE, adr_b);
		check(32'h12, 32'h1a);
		do_op(OP_POLL, adr_b);
		check(fail_st(1'b0, 1'b1), 32'hff10);
		lock_on <= 1'b0;
		supply_ok <= 1'b0;
		do_op(OP_CLEAR, adr_b);
		do_op(OP_POLL, adr_b);
		check(32'h8000, 32'hff10);
		do_op(OP_ERASE, adr_b);
		do_op(OP_POLL, adr_b);
		check(fail_st(1'b1, 1'b0), 32'hff10);
		do_op(OP_CLEAR, adr_b);
		do_op(OP_POLL, adr_b);
		check(32'h8000, 32'hff10);
		supply_ok <= 1'b1;
		do_op(OP_BUF_QUERY, adr_b);
		check(32'h20, 32'h20);
		finish_test();
	end

	initial begin
		repeat (30000) @(posedge ref_clk);
		n_mismatch++;
		$display("MISMATCH %0t watchdog expired", $time);
		finish_test();
	end
endmodule

`default_nettype wire
